// ==== verif/emergency_shutdown_reporter_test.sv ====
// Purpose: Self-checking bench for the shutdown reporter.
// Assumes: Inputs change at the falling edge; park count shortened to 8.
// Notes: The mirror model answers promptly, slowly or never.
`timescale 1ns/1ps
module emergency_shutdown_reporter_test;
    logic clk, rst_n, pwr, rd_req, parked, irq, led, park, mpwr, stby;
    logic [1:0] rd_idx;
    logic [7:0] dly;
    esr_pkg::esr_err_type err;
    esr_pkg::esr_rd_type rd;
    int error_cnt, n_checks, cyc, n;

    esr_top #(.PARK_CYCLES(13'h0008)) dut_u (.clk(clk), .rst_n(rst_n),
        .system_power_request(pwr), .error_in(err),
        .micromirror_array_parked(parked), .hist_rd_req(rd_req),
        .hist_rd_idx(rd_idx), .hist_rd(rd), .host_irq(irq),
        .led_enable(led), .micromirror_array_park(park),
        .micromirror_array_power(mpwr), .mode_standby(stby));
    esr_mirror_model mirror_u (.clk(clk), .park(park), .resp_dly(dly),
        .parked(parked));

    // Prints the counts, then the verdict, and stops.
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    // One-cycle read pulse; returns at the edge where the answer stands.
    task automatic read_hist(input logic [1:0] idx);
        rd_idx = idx;
        rd_req = 1'b1;
        step(1);
        rd_req = 1'b0;
    endtask

    // Errors while off are ignored; power-up takes three edges.
    task automatic power_up_test;
        err = 8'h01;
        pwr = 1'b1;
        step(2);
        err = 8'h00;
        check(12'({led, mpwr, stby}), 12'h001);
        step(1);
        check(12'({led, mpwr, stby, irq}), 12'h00c);
        read_hist(2'h0);
        check(12'(rd), 12'h800);
    endtask

    // Shutdown actions, history capture, and a read that leaves irq set.
    task automatic shutdown_test;
        dly = 8'h03;
        err = 8'h01;
        step(1);
        err = 8'h05;
        check(12'(irq), 12'h001);
        check(12'(led), 12'h000);
        check(12'({park, mpwr}), 12'h003);
        check(12'(stby), 12'h001);
        step(1);
        err = 8'h00;
        read_hist(2'h0);
        check(12'(rd), 12'ha01);
        check(12'(irq), 12'h001);
        n = 0;
        while (park === 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        check(12'({park, mpwr, irq}), 12'h001);
        read_hist(2'h1);
        check(12'(rd), 12'ha05);
    endtask

    // Dropping the power request ends shutdown and wipes the history.
    task automatic cycle_test;
        pwr = 1'b0;
        step(4);
        check(12'({irq, led, stby}), 12'h001);
        step(1);
        read_hist(2'h0);
        check(12'(rd), 12'h800);
    endtask

    // With no park answer the timeout must still cut mirror power.
    task automatic timeout_test;
        pwr = 1'b1;
        dly = 8'hff;
        step(3);
        err = 8'h80;
        step(1);
        err = 8'h00;
        n = 0;
        while (park === 1'b1 && n < 30) begin
            step(1);
            n++;
        end
        check(12'(n), 12'h008);
        check(12'({mpwr, irq}), 12'h001);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // A hang counts as a mismatch and closes the run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            complete_run;
        end
    end

    initial begin
        {rst_n, pwr, rd_req, rd_idx, dly, err} = '0;
        {error_cnt, n_checks, cyc, n} = '0;
        step(5);
        rst_n = 1'b1;
        power_up_test;
        shutdown_test;
        cycle_test;
        timeout_test;
        complete_run;
    end
endmodule

// ==== verif/esr_mirror_model.sv ====
// Purpose: Mirror driver model that answers a park request.
// Assumes: Park request and delay are on the system clock.
// Notes: A delay of ff never answers, so the park timeout is exercised.
`timescale 1ns/1ps
module esr_mirror_model (
    input wire logic clk,
    input wire logic park,
    input wire logic [7:0] resp_dly,
    output logic parked
);
    logic [7:0] cnt_q;

    // Done rises only after the requested wait and drops with the request.
    always_ff @(posedge clk) begin
        if (!park) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign parked = park && resp_dly != 8'hff && cnt_q >= resp_dly;
endmodule

// ==== verilog/esr_map.svh ====
// Purpose: Constants for the emergency shutdown reporter.
// Assumes: A 50 MHz system clock.
// Notes: Sizes here shape the package types, so they are not parameters.
`ifndef ESR_MAP_SVH
`define ESR_MAP_SVH

// ----------------------------------------------------------------------
// Sizes of the error vector and the history store
// ----------------------------------------------------------------------
`define ESR_ERR_W 8
`define ESR_HIST_DEPTH 4
`define ESR_IDX_W 2
`define ESR_CNT_W 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ESR_CLK_MHZ 50
`define ESR_PARK_TIME_US 100
`define ESR_PARK_CYCLES (`ESR_PARK_TIME_US * `ESR_CLK_MHZ)

`endif

// ==== verilog/esr_pkg.sv ====
// Purpose: Types for the emergency shutdown reporter.
// Assumes: esr_map.svh supplies the sizes.
// Notes: All block state is one packed struct.
`include "esr_map.svh"

package esr_pkg;

    // ------------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ESR_OFF,
        ESR_RUN,
        ESR_PARK,
        ESR_SHUT
    } esr_state_type;

    typedef logic [`ESR_ERR_W-1:0] esr_err_type;

    // ------------------------------------------------------------------
    // Host read answer and whole block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [`ESR_CNT_W-1:0] count;
        esr_err_type data;
    } esr_rd_type;

    typedef struct packed {
        logic pwr_meta;
        logic pwr_sync;
        esr_state_type state;
        logic irq;
        logic [12:0] park_cnt;
        esr_err_type [`ESR_HIST_DEPTH-1:0] hist;
        logic [`ESR_CNT_W-1:0] hist_cnt;
        esr_err_type seen;
        esr_rd_type rd;
    } esr_state_all_type;

endpackage

// ==== verilog/esr_top.sv ====
// Purpose: Emergency shutdown sequencing and error history for the host.
// Assumes: Error and park inputs come from logic on clk; the power
//          request comes from a pin.
// Notes: History survives everything but reset and a low power request.
//        The park timeout is a parameter so a bench can shorten it.
`timescale 1ns/1ps
`include "esr_map.svh"

// Behaviour
// - A serious error starts an emergency shutdown and raises host_irq.
// - The shutdown turns the illumination LEDs off.
// - The shutdown parks the micromirror array, then removes its power.
// - The shutdown moves the operating mode to standby.
// - The errors that caused the shutdown are latched into a history.
// - The host can read the captured errors over its command port.
// - Only a low system_power_request ends the shutdown condition.
// - A low system_power_request clears the whole error history.
module esr_top #(
    parameter logic [12:0] PARK_CYCLES = 13'(`ESR_PARK_CYCLES)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic system_power_request,
    input wire esr_pkg::esr_err_type error_in,
    input wire logic micromirror_array_parked,
    input wire logic hist_rd_req,
    input wire logic [`ESR_IDX_W-1:0] hist_rd_idx,
    output esr_pkg::esr_rd_type hist_rd,
    output logic host_irq,
    output logic led_enable,
    output logic micromirror_array_park,
    output logic micromirror_array_power,
    output logic mode_standby
);

    esr_pkg::esr_state_all_type q, d;
    logic new_err;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Only bits not already recorded open a new history entry, so a
    // steady fault cannot flood the store before the host reads it.
    always_comb begin
        d = q;
        d.pwr_meta = system_power_request;
        d.pwr_sync = q.pwr_meta;
        d.rd.valid = 1'b0;
        new_err = |(error_in & ~q.seen);
        case (q.state)
            // Powered down: the interrupt, the park count and the whole
            // history are wiped while the request stays low.
            esr_pkg::ESR_OFF: begin
                d.irq = 1'b0;
                d.park_cnt = '0;
                d.hist = '0;
                d.hist_cnt = '0;
                d.seen = '0;
                if (q.pwr_sync) begin
                    d.state = esr_pkg::ESR_RUN;
                end
            end
            // Operating: any error bit is serious and starts the shutdown.
            esr_pkg::ESR_RUN: begin
                if (!q.pwr_sync) begin
                    d.state = esr_pkg::ESR_OFF;
                end else if (|error_in) begin
                    d.state = esr_pkg::ESR_PARK;
                    d.irq = 1'b1;
                end
            end
            // Parking: the count is cleared on every exit, so it never
            // stands at or above the timeout outside this state.
            esr_pkg::ESR_PARK: begin
                d.park_cnt = q.park_cnt + 13'h0001;
                if (!q.pwr_sync) begin
                    d.state = esr_pkg::ESR_OFF;
                    d.park_cnt = '0;
                end else if (micromirror_array_parked ||
                             q.park_cnt == PARK_CYCLES - 13'h0001) begin
                    d.state = esr_pkg::ESR_SHUT;
                    d.park_cnt = '0;
                end
            end
            // Shut down: nothing but a dropped power request leaves here,
            // which keeps the history readable for as long as needed.
            esr_pkg::ESR_SHUT: begin
                if (!q.pwr_sync) begin
                    d.state = esr_pkg::ESR_OFF;
                end
            end
            default: begin
                d.state = esr_pkg::ESR_OFF;
            end
        endcase
        // Record causing errors from the trigger cycle on. Later errors
        // with new bits still go in while parked or shut, up to the
        // depth of the store; anything beyond that is dropped.
        if (q.pwr_sync && q.state != esr_pkg::ESR_OFF && new_err &&
            q.hist_cnt < `ESR_CNT_W'(`ESR_HIST_DEPTH)) begin
            d.hist[q.hist_cnt[`ESR_IDX_W-1:0]] = error_in;
            d.hist_cnt = q.hist_cnt + `ESR_CNT_W'(1);
            d.seen = q.seen | error_in;
        end
        // Host read answers one cycle later and never touches the irq.
        if (hist_rd_req) begin
            d.rd.valid = 1'b1;
            d.rd.count = q.hist_cnt;
            d.rd.data = (`ESR_CNT_W'(hist_rd_idx) < q.hist_cnt) ?
                        q.hist[hist_rd_idx] : '0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // One register holds all state; reset clears it to the powered-down
    // state with an empty history.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The mirror stays powered while parking; power drops once the park
    // has finished or timed out, or once a dropped power request reaches OFF.
    assign host_irq = q.irq;
    assign led_enable = (q.state == esr_pkg::ESR_RUN);
    assign micromirror_array_park = (q.state == esr_pkg::ESR_PARK);
    assign micromirror_array_power = (q.state == esr_pkg::ESR_RUN) ||
                                     (q.state == esr_pkg::ESR_PARK);
    // Standby covers power-down and shutdown alike, so the host sees one
    // mode for every state in which no image is made.
    assign mode_standby = (q.state != esr_pkg::ESR_RUN);
    assign hist_rd = q.rd;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // All checks sample on the rising edge and rest while reset is held.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    irq_on_fault_a: assert property (
        q.state == esr_pkg::ESR_RUN && q.pwr_sync && |error_in |=>
        host_irq && micromirror_array_park)
        else $error("Fault did not raise irq and start park.");
    led_off_a: assert property (
        host_irq |-> !led_enable)
        else $error("LEDs on during shutdown.");
    park_then_off_a: assert property (
        $fell(micromirror_array_park) && q.pwr_sync |->
        !micromirror_array_power && $past(micromirror_array_power))
        else $error("Mirror power not removed after park.");
    standby_mode_a: assert property (
        $rose(host_irq) |-> mode_standby)
        else $error("Mode not standby at shutdown.");
    hist_capture_a: assert property (
        q.state == esr_pkg::ESR_RUN && q.pwr_sync && |error_in |=>
        q.hist_cnt == 3'h1 && q.hist[0] == $past(error_in))
        else $error("Causing errors not latched.");
    read_answer_a: assert property (
        hist_rd_req && hist_rd_idx == 2'h0 && q.hist_cnt != 3'h0 |=>
        hist_rd.valid && hist_rd.data == $past(q.hist[0]))
        else $error("History read returned wrong entry.");
    stay_shut_a: assert property (
        host_irq && q.pwr_sync |=> host_irq)
        else $error("Shutdown left without power cycle.");
    clear_hist_a: assert property (
        q.state == esr_pkg::ESR_OFF |=> q.hist_cnt == 3'h0 && q.hist == '0)
        else $error("History survived power cycle.");
    irq_hold_read_a: assert property (
        host_irq && hist_rd_req && q.pwr_sync |=> host_irq)
        else $error("Read cleared the irq.");
    park_bound_a: assert property (
        q.park_cnt < PARK_CYCLES)
        else $error("Park ran past its timeout.");

    // ------------------------------------------------------------------
    // Shutdown sequence, history and power-up checks
    // ------------------------------------------------------------------
    // Parking needs the array powered; cutting power first would leave
    // the mirrors wherever they happened to stop.
    park_powered_a: assert property (
        micromirror_array_park |-> micromirror_array_power)
        else $error("Park requested with mirror power off.");
    parked_exit_a: assert property (
        q.state == esr_pkg::ESR_PARK && q.pwr_sync &&
        micromirror_array_parked |=> !micromirror_array_power)
        else $error("Mirror power kept after park done.");
    // A driver that never answers must not keep the array powered.
    timeout_cut_a: assert property (
        q.state == esr_pkg::ESR_PARK && q.pwr_sync &&
        q.park_cnt == PARK_CYCLES - 13'h0001 |=>
        !micromirror_array_power && !micromirror_array_park)
        else $error("Park timeout did not cut mirror power.");
    shut_standby_a: assert property (
        host_irq |-> mode_standby)
        else $error("Mode left standby during shutdown.");
    hist_limit_a: assert property (
        q.hist_cnt <= 3'h4)
        else $error("History count ran past the store.");
    read_pulse_a: assert property (
        !hist_rd_req |=> !hist_rd.valid)
        else $error("Read answer without a request.");
    // Entries are only ever added until power cycles.
    hist_kept_a: assert property (
        q.state == esr_pkg::ESR_SHUT && q.pwr_sync |=>
        q.hist_cnt >= $past(q.hist_cnt))
        else $error("History shrank before power cycle.");
    power_up_a: assert property (
        q.state == esr_pkg::ESR_OFF && q.pwr_sync |=>
        led_enable && micromirror_array_power && !mode_standby)
        else $error("Power request did not start operation.");
    off_drops_irq_a: assert property (
        q.state == esr_pkg::ESR_OFF |=> !host_irq)
        else $error("Interrupt kept after power cycle.");

    // Main scenarios that the bench is expected to reach.
    shutdown_c: cover property ($rose(host_irq));
    parked_c: cover property (micromirror_array_park &&
                              micromirror_array_parked);
    recover_c: cover property ($fell(host_irq));
    read_c: cover property (hist_rd.valid && hist_rd.count != 3'h0);
    timeout_c: cover property (q.state == esr_pkg::ESR_PARK &&
                               q.park_cnt == PARK_CYCLES - 13'h0001);

endmodule
